// *** design/dsrs_cfg.svh ***
// constants for the display status readback and sleep entry block
//
// Contract
// - command 0Ch returns pixel format byte
// - nibbles report video and command depth
// - command 0Dh returns image mode byte
// - image bit 7 shows vertical scrolling
// - image bit 6 always reads zero
// - image bit 5 shows display inversion
// - image bits 4,3 show forced white/black
// - image bits 2..0 carry gamma curve
// - image byte zero at power-on, soft reset
// - command 0Eh returns signal mode byte
// - signal bit 0 shows serial link error
// - command 0Fh returns self diagnostic byte
// - status reads accepted in every power state
// - command 10h enters sleep, no parameters
// - interface, memory, registers work while sleeping
// - command 11h restarts converter, oscillator, scan
`ifndef DSRS_CFG_SVH
`define DSRS_CFG_SVH
`define DSRS_CMD_RD_PIXFMT  8'h0C
`define DSRS_CMD_RD_IMAGE   8'h0D
`define DSRS_CMD_RD_SIGNAL  8'h0E
`define DSRS_CMD_RD_DIAG    8'h0F
`define DSRS_CMD_SLEEP_IN   8'h10
`define DSRS_CMD_SLEEP_OUT  8'h11
`define DSRS_PIXFMT_RST     8'h77
`define DSRS_IMAGE_RST      8'h00
`define DSRS_FMT_16         4'h5
`define DSRS_FMT_18         4'h6
`define DSRS_FMT_24         4'h7
`define DSRS_SLEEP_WAIT_MS  120
`define DSRS_CLK_MHZ        250
`endif

// *** design/dsrs_pkg.sv ***
// types for the display status readback and sleep entry block
`default_nettype none
package dsrs_pkg;
    typedef logic [7:0] dsrs_byte_t;
    typedef logic [3:0] dsrs_fmt_t;
    typedef enum logic [1:0] {
        DSRS_SLEEP = 2'b00,
        DSRS_AWAKE = 2'b01
    } dsrs_pwr_e;
endpackage
`default_nettype wire

// *** design/dsrs_core.sv ***
// command decoder for status readback and sleep entry/exit
`include "dsrs_cfg.svh"
`default_nettype none
module dsrs_core (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               clk_en,
    input  wire logic               soft_rst,
    input  wire logic               cmd_valid,
    input  wire dsrs_pkg::dsrs_byte_t cmd_code,
    input  wire dsrs_pkg::dsrs_fmt_t  video_fmt,
    input  wire dsrs_pkg::dsrs_fmt_t  cmd_fmt,
    input  wire logic               vscroll_on,
    input  wire logic               invert_on,
    input  wire logic               all_white,
    input  wire logic               all_black,
    input  wire logic [2:0]         gamma_sel,
    input  wire logic               tear_en,
    input  wire logic               tear_mode,
    input  wire logic               line_sync,
    input  wire logic               frame_sync,
    input  wire logic               pclk_active,
    input  wire logic               pixel_valid_line,
    input  wire logic               link_error,
    input  wire logic               reg_load_ok,
    input  wire logic               func_ok,
    output logic                    rd_valid,
    output dsrs_pkg::dsrs_byte_t    rd_data,
    output logic                    sleeping,
    output logic                    panel_blank,
    output logic                    scan_run,
    output logic                    osc_run,
    output logic                    dcdc_on
);
    import dsrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_read(input dsrs_byte_t c);
        is_read = (c == `DSRS_CMD_RD_PIXFMT) || (c == `DSRS_CMD_RD_IMAGE) ||
                  (c == `DSRS_CMD_RD_SIGNAL) || (c == `DSRS_CMD_RD_DIAG);
    endfunction

    // undefined depth codes pass through; the host owns what it set
    function automatic dsrs_byte_t pix_byte(input dsrs_fmt_t v,
                                           input dsrs_fmt_t c);
        pix_byte = {v, c};
    endfunction

    dsrs_pwr_e  pwr_q;
    dsrs_byte_t rd_data_q;
    logic       rd_valid_q;

    ////////////////////////////////////////////////////////////////////////
    // power state: sleep after reset, entry and exit by command
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwr_q <= DSRS_SLEEP;
        end else if (clk_en) begin
            if (soft_rst) begin
                pwr_q <= DSRS_SLEEP;
            end else if (cmd_valid && cmd_code == `DSRS_CMD_SLEEP_IN) begin
                pwr_q <= DSRS_SLEEP;
            end else if (cmd_valid && cmd_code == `DSRS_CMD_SLEEP_OUT) begin
                pwr_q <= DSRS_AWAKE;
            end
        end
    end

    // analog controls follow power state; interface keeps running asleep
    assign sleeping    = (pwr_q == DSRS_SLEEP);
    assign panel_blank = sleeping;
    assign scan_run    = !sleeping;
    assign osc_run     = !sleeping;
    assign dcdc_on     = !sleeping;

    ////////////////////////////////////////////////////////////////////////
    // readback: byte captured on the command cycle, held until next read or soft reset
    // line levels are sampled here so the byte reflects command time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else if (clk_en) begin
            rd_valid_q <= 1'b0;
            if (soft_rst) begin
                rd_data_q <= 8'h00;
            end else if (cmd_valid && is_read(cmd_code)) begin
                rd_valid_q <= 1'b1;
                unique case (cmd_code)
                    `DSRS_CMD_RD_PIXFMT:
                        rd_data_q <= pix_byte(video_fmt, cmd_fmt);
                    `DSRS_CMD_RD_IMAGE:
                        rd_data_q <= {vscroll_on,
                                      1'b0,
                                      invert_on,
                                      all_white, all_black,
                                      gamma_sel};
                    `DSRS_CMD_RD_SIGNAL:
                        rd_data_q <= {tear_en, tear_mode, line_sync,
                                      frame_sync, pclk_active,
                                      pixel_valid_line, 1'b0,
                                      link_error};
                    `DSRS_CMD_RD_DIAG:
                        rd_data_q <= {reg_load_ok, func_ok, 6'h00};
                    default:                              // filtered above
                        rd_data_q <= rd_data_q;
                endcase
            end
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data  = rd_data_q;

    ////////////////////////////////////////////////////////////////////////
    // checks: each taken command is judged at the next edge
    // a command counts only on an enabled edge without soft reset
    logic take_any;
    logic take_read;
    logic take_sleep;
    logic take_wake;
    logic take_other;
    assign take_any   = clk_en && cmd_valid && !soft_rst;
    assign take_read  = take_any && is_read(cmd_code);
    assign take_sleep = take_any && cmd_code == `DSRS_CMD_SLEEP_IN;
    assign take_wake  = take_any && cmd_code == `DSRS_CMD_SLEEP_OUT;
    assign take_other = take_any && !is_read(cmd_code)
        && !take_sleep && !take_wake;

    // sleep entry stops converter, oscillator and scan
    sleep_entry_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_sleep |=> sleeping && panel_blank
            && !dcdc_on && !osc_run && !scan_run)
        else $error("sleep entry did not stop power blocks");

    // sleep exit restarts converter, oscillator and scan
    sleep_exit_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_wake |=> !sleeping && !panel_blank
            && dcdc_on && osc_run && scan_run)
        else $error("sleep exit did not restart power blocks");

    // soft reset lands in sleep with everything stopped
    soft_sleep_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && soft_rst |=> sleeping && panel_blank
            && !dcdc_on && !osc_run && !scan_run)
        else $error("soft reset did not return to sleep");

    // every status read is answered one edge later
    read_any_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_read
            |=> rd_valid)
        else $error("status read not answered");

    // reads asleep answer and leave the power state alone
    read_asleep_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_read && sleeping
            |=> rd_valid && sleeping)
        else $error("read while asleep mishandled");

    // reads awake answer and leave the power state alone
    read_awake_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_read && !sleeping
            |=> rd_valid && !sleeping)
        else $error("read while awake mishandled");

    // pixel format read is answered
    pix_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_PIXFMT
            |=> rd_valid)
        else $error("pixel format read not answered");

    // video depth high nibble, command depth low nibble
    pix_byte_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_PIXFMT
            |=> rd_data == {$past(video_fmt), $past(cmd_fmt)})
        else $error("pixel format byte wrong");

    // image mode read is answered
    image_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_valid)
        else $error("image mode read not answered");

    // top bit follows vertical scrolling
    image_scroll_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_data[7] == $past(vscroll_on))
        else $error("image scroll bit wrong");

    // no horizontal scrolling, so bit 6 is tied low
    image_hscroll_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_data[6] == 1'b0)
        else $error("image spare bit set");

    // bit 5 follows display inversion
    image_invert_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_data[5] == $past(invert_on))
        else $error("image inversion bit wrong");

    // forced white and forced black flags
    image_fill_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_data[4:3] == {$past(all_white), $past(all_black)})
        else $error("image fill bits wrong");

    // gamma curve code in the low bits
    image_gamma_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_IMAGE
            |=> rd_data[2:0] == $past(gamma_sel))
        else $error("image gamma bits wrong");

    // soft reset clears the readback byte
    image_clear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && soft_rst
            |=> rd_data == `DSRS_IMAGE_RST)
        else $error("soft reset did not clear readback");

    // signal mode read is answered
    signal_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_SIGNAL
            |=> rd_valid)
        else $error("signal mode read not answered");

    // link error in bit 0, bit 1 tied low
    signal_error_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_SIGNAL
            |=> rd_data[1:0] == {1'b0, $past(link_error)})
        else $error("signal error bits wrong");

    // tearing enable and mode on top
    signal_tear_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_SIGNAL
            |=> rd_data[7:6] == {$past(tear_en), $past(tear_mode)})
        else $error("signal tearing bits wrong");

    // sync levels as seen on the command cycle
    signal_sync_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_SIGNAL
            |=> rd_data[5:4] == {$past(line_sync), $past(frame_sync)})
        else $error("signal sync bits wrong");

    // pixel clock and valid line as seen on the command cycle
    signal_clock_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_SIGNAL
            |=> rd_data[3:2] == {$past(pclk_active), $past(pixel_valid_line)})
        else $error("signal clock bits wrong");

    // diagnostic read is answered
    diag_read_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_DIAG
            |=> rd_valid)
        else $error("diagnostic read not answered");

    // two check results on top, the rest low
    diag_byte_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_any && cmd_code == `DSRS_CMD_RD_DIAG
            |=> rd_data == {$past(reg_load_ok), $past(func_ok), 6'h00})
        else $error("diagnostic byte wrong");

    // sleep entry keeps the last readback byte
    sleep_keeps_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_sleep
            |=> $stable(rd_data) && !rd_valid)
        else $error("sleep entry disturbed readback");

    // sleep exit keeps the last readback byte
    wake_keeps_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_wake
            |=> $stable(rd_data) && !rd_valid)
        else $error("sleep exit disturbed readback");

    // strobe is a single pulse per taken read
    valid_pulse_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && !take_read
            |=> !rd_valid)
        else $error("read strobe without a read");

    // byte holds until the next read or soft reset
    data_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && !soft_rst && !take_read
            |=> $stable(rd_data))
        else $error("readback byte changed without a read");

    // power state moves only on sleep commands or resets
    power_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && !soft_rst && !take_sleep && !take_wake
            |=> $stable(sleeping))
        else $error("power state moved without a command");

    // codes outside the set are dropped without a trace
    unknown_code_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        take_other
            |=> !rd_valid && $stable(sleeping))
        else $error("unknown code had an effect");

    // a low enable freezes every register
    freeze_all_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !clk_en
            |=> $stable(rd_data) && $stable(rd_valid) && $stable(sleeping))
        else $error("state moved while frozen");

    // soft reset wins over a command in the same cycle
    soft_wins_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        clk_en && soft_rst && cmd_valid
            |=> sleeping && !rd_valid && rd_data == `DSRS_IMAGE_RST)
        else $error("command beat soft reset");

    read_in_sleep_c: cover property (@(posedge sys_clk) disable iff (rst)
        sleeping && cmd_valid && cmd_code == `DSRS_CMD_RD_IMAGE);
    wake_c: cover property (@(posedge sys_clk) disable iff (rst)
        sleeping ##1 !sleeping);
    reenter_c: cover property (@(posedge sys_clk) disable iff (rst)
        !sleeping ##1 sleeping);
    freeze_c: cover property (@(posedge sys_clk) disable iff (rst)
        !clk_en && cmd_valid);
    soft_cmd_c: cover property (@(posedge sys_clk) disable iff (rst)
        clk_en && soft_rst && cmd_valid);
endmodule // dsrs_core
`default_nettype wire

// *** verif/dsrs_host.sv ***
// host-side model issuing one command strobe per request
`default_nettype none
module dsrs_host #(
    parameter int HOLD = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       req,
    input  wire logic [7:0] req_code,
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q;
    // idle code toggles so a stale byte never looks valid
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_code  <= 8'h00;
        end else begin
            cmd_valid <= req;
            cmd_code  <= req ? req_code : ~cmd_code;
        end
    end
    // exit held off after entry; wait scaled down for run time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) wait_q <= 0;
        else if (req && req_code == 8'h10) wait_q <= HOLD;
        else if (wait_q != 0) wait_q <= wait_q - 1;
    end
    assign busy = (wait_q != 0);
endmodule // dsrs_host
`default_nettype wire

// *** verif/display_status_readback_sleep_entry_bench.sv ***
// self-checking bench for status readback and sleep entry
`default_nettype none
module display_status_readback_sleep_entry_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dsrs_pkg::*;
    logic sys_clk = 0, rst = 1, soft_rst = 0, req = 0, exp_sl = 1, en = 1;
    logic [7:0] req_code = 8'h00, exp_rd = 8'h00;
    logic cmd_valid, busy, rd_valid, sleeping, blank, scan, osc, dcdc;
    dsrs_byte_t cmd_code, rd_data;
    dsrs_fmt_t vf = 4'h5, cf = 4'h5;
    logic [2:0] gam = 3'h0;
    logic [12:0] st = 13'h0000;
    int n_mismatch = 0, checked = 0, cyc = 0;
    logic [7:0] codes [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
                              8'h5A};
    dsrs_core DUT (.sys_clk, .rst, .clk_en(en), .soft_rst, .cmd_valid,
        .cmd_code, .video_fmt(vf), .cmd_fmt(cf), .vscroll_on(st[12]),
        .invert_on(st[11]), .all_white(st[10]), .all_black(st[9]),
        .gamma_sel(gam), .tear_en(st[8]), .tear_mode(st[7]),
        .line_sync(st[6]), .frame_sync(st[5]), .pclk_active(st[4]),
        .pixel_valid_line(st[3]), .link_error(st[2]), .reg_load_ok(st[1]),
        .func_ok(st[0]), .rd_valid, .rd_data, .sleeping,
        .panel_blank(blank), .scan_run(scan), .osc_run(osc), .dcdc_on(dcdc));
    dsrs_host #(.HOLD(8)) host (.sys_clk, .rst, .req, .req_code, .cmd_valid,
        .cmd_code, .busy);
    always #2 sys_clk = ~sys_clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic cmp_byte(string what, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_pwr(logic s);
        cmp_byte("power outputs", {3'h0, s, s, ~s, ~s, ~s},
                 {3'h0, sleeping, blank, scan, osc, dcdc});
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // new random levels, one command, answer one cycle after it lands
    task automatic issue(logic [7:0] c);
        logic rd;
        st = 13'($urandom);
        gam = 3'($urandom_range(4));
        vf = 4'(5 + $urandom_range(2));
        cf = 4'(5 + $urandom_range(2));
        rd = (c >= 8'h0C && c <= 8'h0F);
        if (rd) exp_rd = (c == 8'h0C) ? {vf, cf}
            : (c == 8'h0D) ? {st[12], 1'b0, st[11:9], gam}
            : (c == 8'h0E) ? {st[8:3], 1'b0, st[2]} : {st[1:0], 6'h00};
        if (c == 8'h10) exp_sl = 1;
        if (c == 8'h11) exp_sl = 0;
        @(posedge sys_clk) #1;
        req = 1;
        req_code = c;
        @(posedge sys_clk) #1;
        req = 0;
        @(posedge sys_clk) #1;
        cmp_byte("read data", exp_rd, rd_data);
        cmp_byte("read strobe", {7'h0, rd}, {7'h0, rd_valid});
        cmp_pwr(exp_sl);
    endtask
    initial begin
        void'($urandom(32'h9A38));
        repeat (12) @(posedge sys_clk);
        #1 rst = 0;
        cmp_byte("reset data", 8'h00, rd_data);
        cmp_pwr(1'b1);
        $display("test reset done");
        for (int i = 0; i < 60; i++) begin
            int k;
            k = $urandom_range(6);
            while (codes[k] == 8'h11 && busy) @(posedge sys_clk) #1;
            issue(codes[k]);
        end
        $display("test command mix done");
        // frozen edges drop a power command and hold every output
        while (busy) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1;
        en = 0;
        req = 1;
        req_code = exp_sl ? 8'h11 : 8'h10;
        @(posedge sys_clk) #1 req = 0;
        repeat (2) @(posedge sys_clk);
        #1 en = 1;
        cmp_pwr(exp_sl);
        cmp_byte("frozen data", exp_rd, rd_data);
        cmp_byte("frozen strobe", 8'h00, {7'h0, rd_valid});
        $display("test clock enable done");
        issue(8'h0F);
        @(posedge sys_clk) #1 soft_rst = 1;
        @(posedge sys_clk) #1 soft_rst = 0;
        cmp_byte("soft reset data", 8'h00, rd_data);
        cmp_pwr(1'b1);
        $display("test soft reset done");
        test_done();
    end
endmodule // display_status_readback_sleep_entry_bench
`default_nettype wire
